// *** design/ffmd_detector.sv ***
// Freefall/motion event detector with its Avalon-MM register slave.
// Assumes acceleration words from logic on the same clock, refreshed at least once per sample step.
`timescale 1ns/1ps
`default_nettype none
`include "ffmd_regs.svh"

// Functional notes
// - Latched source read clears event and flags.
// - Combine select: zero AND freefall, one OR.
// - Axis enable bits include axis; default off.
// - Latched flags freeze when event sets.
// - Held event blocks new flag updates.
// - Unlatched flags show real-time detection status.
// - Freefall: enabled magnitudes at most threshold.
// - Motion: any enabled magnitude above threshold.
// - Event set from debounced axis combination.
// - Source layout: event bit seven, axis pairs.
// - Polarity flag one means negative acceleration.
// - Disabled axis flags always read zero.
// - Interrupt gates event with enable, route.
// - Threshold seven bits unsigned, default zero.
// - Thresholds reach eight g at any range.
// - Low noise limits threshold to four g.
// - Clear mode zeroes counter without condition.
// - Default mode decrements counter, floor zero.
// - Count register eight bits, reset zero.
// - Event at count; counting saturates at it.
// - Counter steps once per rate-dependent sample.
// - Latched read restarts debounce delay.
// - Config: latch, combine, Z Y X enables.
module ffmd_detector #(
  parameter int unsigned CYCLES_PER_US = `FFMD_NS_PER_US / `FFMD_CLK_PERIOD_NS
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  input  wire logic [`FFMD_ADDR_W-1:0]    avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire ffmd_pkg::ffmd_accel_t      accel_i,
  output logic                            sample_tick_o,
  output logic                            event_active_o,
  output logic                            irq_int1_o,
  output logic                            irq_int2_o
);
  import ffmd_pkg::*;

  ffmd_state_t                 st_r;
  ffmd_state_t                 st_nxt;
  logic                        req;
  logic        [5:0]           idx;
  logic                        take;
  logic                        src_read;
  logic        [`FFMD_TMR_W-1:0] step_cycles;
  logic                        tick;
  logic        [2:0]           axis_en;
  logic        [6:0]           ths_eff;
  logic        [2:0]           above;
  logic        [2:0]           below;
  logic        [2:0]           neg;
  logic        [1:0]           src_bits [3];
  logic        [3:0]           shift;
  logic                        cond;
  logic        [7:0]           dbc_n;
  logic                        reached;
  logic        [5:0]           raw_flags;
  logic        [7:0]           src_byte;

  // ----------------------------------------------------------------------------
  // Sample step table
  // ----------------------------------------------------------------------------
  // Step time in microseconds for a rate code (0 = fastest) and oversampling mode.
  function automatic logic [`FFMD_TMR_W-1:0] step_us(input logic [2:0] rate, input ffmd_osm_t osm);
    logic [`FFMD_TMR_W-1:0] us;
    us = `FFMD_STEP_US_20;
    case (rate)
      3'h0:    us = `FFMD_STEP_US_1;
      3'h1:    us = `FFMD_STEP_US_2;
      3'h2:    us = (osm == OSM_HIGHRES) ? `FFMD_STEP_US_2 : `FFMD_STEP_US_5;
      3'h3:    us = (osm == OSM_HIGHRES) ? `FFMD_STEP_US_2 : `FFMD_STEP_US_10;
      3'h4:    us = (osm == OSM_HIGHRES) ? `FFMD_STEP_US_2 : `FFMD_STEP_US_20;
      3'h5:    us = (osm == OSM_HIGHRES) ? `FFMD_STEP_US_2 :
                    (osm == OSM_NORMAL)  ? `FFMD_STEP_US_20 : `FFMD_STEP_US_80;
      default: us = (osm == OSM_HIGHRES)  ? `FFMD_STEP_US_2 :
                    (osm == OSM_NORMAL)   ? `FFMD_STEP_US_20 :
                    (osm == OSM_LOWNOISE) ? `FFMD_STEP_US_80 : `FFMD_STEP_US_160;
    endcase
    return us;
  endfunction : step_us

  // ----------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------
  // One wait cycle per access: the read word is registered before waitrequest drops.
  assign req               = avs_read_i | avs_write_i;
  assign idx               = avs_address_i[`FFMD_ADDR_W-1:`FFMD_IDX_LSB];
  assign take              = req & st_r.ack;
  assign src_read          = take & avs_read_i & (idx == `FFMD_IDX_SOURCE);
  assign avs_waitrequest_o = req & ~st_r.ack;
  assign avs_readdata_o    = st_r.rdata;

  // ----------------------------------------------------------------------------
  // Per-axis comparison
  // ----------------------------------------------------------------------------
  assign axis_en = st_r.cfg[`FFMD_CFG_AXIS_HI:`FFMD_CFG_AXIS_LO];
  assign ths_eff = (st_r.sysctl[`FFMD_SYS_LOWNOISE] && st_r.ths[`FFMD_THS_HI:0] > `FFMD_LN_THS_MAX) ?
                   `FFMD_LN_THS_MAX : st_r.ths[`FFMD_THS_HI:0];
  // Magnitudes are rescaled to threshold units so the compare spans eight g at every range.
  assign shift   = 4'(`FFMD_MAG_SHIFT_BASE) + 4'(`FFMD_FS_MAX)
                   - 4'((st_r.sysctl[`FFMD_SYS_FS_HI:`FFMD_SYS_FS_LO] > `FFMD_FS_MAX) ?
                   `FFMD_FS_MAX : st_r.sysctl[`FFMD_SYS_FS_HI:`FFMD_SYS_FS_LO]);

  ffmd_axis_cmp #(
    .ACC_W ($bits(accel_i.x)),
    .THS_W ($bits(ths_eff)),
    .SHF_W ($bits(shift))
  ) ffmd_axis_cmp_x_i (
    .accel_i     (accel_i.x),
    .enable_i    (axis_en[0]),
    .shift_i     (shift),
    .thresh_i    (ths_eff),
    .flags_i     (st_r.flags[1:0]),
    .above_o     (above[0]),
    .below_o     (below[0]),
    .negative_o  (neg[0]),
    .src_flags_o (src_bits[0])
  );

  ffmd_axis_cmp #(
    .ACC_W ($bits(accel_i.y)),
    .THS_W ($bits(ths_eff)),
    .SHF_W ($bits(shift))
  ) ffmd_axis_cmp_y_i (
    .accel_i     (accel_i.y),
    .enable_i    (axis_en[1]),
    .shift_i     (shift),
    .thresh_i    (ths_eff),
    .flags_i     (st_r.flags[3:2]),
    .above_o     (above[1]),
    .below_o     (below[1]),
    .negative_o  (neg[1]),
    .src_flags_o (src_bits[1])
  );

  ffmd_axis_cmp #(
    .ACC_W ($bits(accel_i.z)),
    .THS_W ($bits(ths_eff)),
    .SHF_W ($bits(shift))
  ) ffmd_axis_cmp_z_i (
    .accel_i     (accel_i.z),
    .enable_i    (axis_en[2]),
    .shift_i     (shift),
    .thresh_i    (ths_eff),
    .flags_i     (st_r.flags[5:4]),
    .above_o     (above[2]),
    .below_o     (below[2]),
    .negative_o  (neg[2]),
    .src_flags_o (src_bits[2])
  );

  // Event flag of each axis: a high-g excursion (above threshold) in both motion and freefall mode.
  assign raw_flags = {above[2], neg[2] & above[2], above[1], neg[1] & above[1], above[0], neg[0] & above[0]};
  // With no axis enabled the block is off, so freefall needs at least one enabled axis.
  assign cond      = st_r.cfg[`FFMD_CFG_COMBINE] ? (|above) :
                     ((|axis_en) && ((below | ~axis_en) == 3'h7));

  assign src_byte  = {st_r.ea, 1'b0, src_bits[2], src_bits[1], src_bits[0]};

  assign step_cycles = step_us(st_r.sysctl[`FFMD_SYS_RATE_HI:`FFMD_SYS_RATE_LO],
                               ffmd_osm_t'(st_r.sysctl[`FFMD_SYS_OSM_HI:`FFMD_SYS_OSM_LO]))
                       * `FFMD_TMR_W'(CYCLES_PER_US);
  assign tick        = (st_r.tmr >= step_cycles - `FFMD_TMR_W'(1));

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    st_nxt  = st_r;
    dbc_n   = st_r.dbc;
    reached = 1'b0;

    // Bus handshake and read word.
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack && avs_read_i)
    begin
      case (idx)
        `FFMD_IDX_CONFIG:    st_nxt.rdata = {24'h000000, st_r.cfg[7:3], 3'h0};
        `FFMD_IDX_SOURCE:    st_nxt.rdata = {24'h000000, src_byte};
        `FFMD_IDX_THRESHOLD: st_nxt.rdata = {24'h000000, st_r.ths};
        `FFMD_IDX_COUNT:     st_nxt.rdata = {24'h000000, st_r.cnt_lim};
        `FFMD_IDX_SYSCTL:    st_nxt.rdata = {24'h000000, st_r.sysctl};
        `FFMD_IDX_IRQCTL:    st_nxt.rdata = {24'h000000, 6'h00, st_r.irqctl[1:0]};
        default:             st_nxt.rdata = 32'h00000000;
      endcase
    end

    // Register writes take effect at the edge where waitrequest is low.
    if (take && avs_write_i && avs_byteenable_i[0])
    begin
      case (idx)
        `FFMD_IDX_CONFIG:    st_nxt.cfg     = {avs_writedata_i[7:3], 3'h0};
        `FFMD_IDX_THRESHOLD: st_nxt.ths     = avs_writedata_i[7:0];
        `FFMD_IDX_COUNT:     st_nxt.cnt_lim = avs_writedata_i[7:0];
        `FFMD_IDX_SYSCTL:    st_nxt.sysctl  = avs_writedata_i[7:0];
        `FFMD_IDX_IRQCTL:    st_nxt.irqctl  = {6'h00, avs_writedata_i[1:0]};
        default:             st_nxt.cfg     = st_r.cfg;
      endcase
    end

    // A latched source read clears the event, the flags and the debounce count.
    if (src_read && st_r.cfg[`FFMD_CFG_LATCH])
    begin
      st_nxt.ea    = 1'b0;
      st_nxt.flags = `FFMD_RST_FLAGS;
      st_nxt.dbc   = `FFMD_RST_BYTE;
    end

    // Sample divider.
    st_nxt.tmr = tick ? `FFMD_TMR_W'(0) : st_r.tmr + `FFMD_TMR_W'(1);

    // The sample step runs after any clear, so an event in the clearing cycle is kept.
    if (tick && !(st_nxt.ea && st_r.cfg[`FFMD_CFG_LATCH]))
    begin
      dbc_n = st_nxt.dbc;
      if (cond)
      begin
        if (dbc_n < st_r.cnt_lim)
          dbc_n = dbc_n + 8'h01;
        else
          dbc_n = st_r.cnt_lim;
      end
      else if (st_r.ths[`FFMD_THS_MODE])
        dbc_n = `FFMD_RST_BYTE;
      else if (dbc_n > st_r.cnt_lim)
        dbc_n = st_r.cnt_lim;
      else if (dbc_n != `FFMD_RST_BYTE)
        dbc_n = dbc_n - 8'h01;
      st_nxt.dbc = dbc_n;
      reached    = cond && (dbc_n == st_r.cnt_lim);

      if (st_r.cfg[`FFMD_CFG_LATCH])
      begin
        st_nxt.ea    = reached;
        st_nxt.flags = raw_flags;
      end
      else
      begin
        // In decrement mode the event lingers until the count has run back to zero.
        if (cond)
          st_nxt.ea = st_r.ea | reached;
        else
          st_nxt.ea = st_r.ea & ~st_r.ths[`FFMD_THS_MODE] & (dbc_n != `FFMD_RST_BYTE);
        st_nxt.flags = raw_flags;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r         <= '0;
      st_r.cfg     <= `FFMD_RST_BYTE;
      st_r.ths     <= `FFMD_RST_BYTE;
      st_r.cnt_lim <= `FFMD_RST_BYTE;
      st_r.sysctl  <= `FFMD_RST_BYTE;
      st_r.irqctl  <= `FFMD_RST_BYTE;
      st_r.flags   <= `FFMD_RST_FLAGS;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign sample_tick_o  = tick;
  assign event_active_o = st_r.ea;
  assign irq_int1_o     = st_r.ea & st_r.irqctl[`FFMD_IRQ_ENABLE] & ~st_r.irqctl[`FFMD_IRQ_ROUTE];
  assign irq_int2_o     = st_r.ea & st_r.irqctl[`FFMD_IRQ_ENABLE] & st_r.irqctl[`FFMD_IRQ_ROUTE];

endmodule : ffmd_detector

// ----------------------------------------------------------------------------
// Per-axis magnitude compare and source masking
// ----------------------------------------------------------------------------
// One copy per axis keeps the three channels identical by construction.
module ffmd_axis_cmp #(
  parameter int unsigned ACC_W = 14,
  parameter int unsigned THS_W = 7,
  parameter int unsigned SHF_W = 4
) (
  input  wire logic signed [ACC_W-1:0] accel_i,
  input  wire logic                    enable_i,
  input  wire logic        [SHF_W-1:0] shift_i,
  input  wire logic        [THS_W-1:0] thresh_i,
  input  wire logic        [1:0]       flags_i,
  output logic                         above_o,
  output logic                         below_o,
  output logic                         negative_o,
  output logic             [1:0]       src_flags_o
);
  import ffmd_pkg::*;

  logic [ACC_W-1:0] mag;
  logic [ACC_W-1:0] scaled;

  // The most negative word folds onto its own pattern, which still reads as the largest magnitude.
  assign mag         = accel_i[ACC_W-1] ? ACC_W'(-accel_i) : ACC_W'(accel_i);
  assign scaled      = mag >> shift_i;
  assign above_o     = enable_i & (scaled > ACC_W'(thresh_i));
  assign below_o     = enable_i & (scaled <= ACC_W'(thresh_i));
  assign negative_o  = enable_i & accel_i[ACC_W-1];
  // Masking at read time keeps a disabled axis silent even while its stored flags are frozen.
  assign src_flags_o = flags_i & {2{enable_i}};

endmodule : ffmd_axis_cmp
`default_nettype wire

// *** inc/ffmd_regs.svh ***
// Register indices, field positions, reset values and timing figures of the freefall/motion detector.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FFMD_REGS_SVH
`define FFMD_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define FFMD_IDX_CONFIG      6'h15
`define FFMD_IDX_SOURCE      6'h16
`define FFMD_IDX_THRESHOLD   6'h17
`define FFMD_IDX_COUNT       6'h18
`define FFMD_IDX_SYSCTL      6'h2A
`define FFMD_IDX_IRQCTL      6'h2D
`define FFMD_ADDR_W          8
`define FFMD_IDX_LSB         2

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FFMD_CFG_LATCH       7
`define FFMD_CFG_COMBINE     6
`define FFMD_CFG_AXIS_HI     5
`define FFMD_CFG_AXIS_LO     3
`define FFMD_SRC_EA          7
`define FFMD_THS_MODE        7
`define FFMD_THS_HI          6
`define FFMD_SYS_LOWNOISE    0
`define FFMD_SYS_RATE_HI     3
`define FFMD_SYS_RATE_LO     1
`define FFMD_SYS_OSM_HI      5
`define FFMD_SYS_OSM_LO      4
`define FFMD_SYS_FS_HI       7
`define FFMD_SYS_FS_LO       6
`define FFMD_IRQ_ENABLE      0
`define FFMD_IRQ_ROUTE       1

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define FFMD_RST_BYTE        8'h00
`define FFMD_RST_FLAGS       6'h00
`define FFMD_LN_THS_MAX      7'h3F
`define FFMD_MAG_SHIFT_BASE  6
`define FFMD_FS_MAX          2'h2

// ----------------------------------------------------------------------------
// Timing: clock period in nanoseconds and debounce step times in microseconds
// ----------------------------------------------------------------------------
`define FFMD_CLK_PERIOD_NS   10
`define FFMD_NS_PER_US       1000
`define FFMD_STEP_US_1       1250
`define FFMD_STEP_US_2       2500
`define FFMD_STEP_US_5       5000
`define FFMD_STEP_US_10      10000
`define FFMD_STEP_US_20      20000
`define FFMD_STEP_US_80      80000
`define FFMD_STEP_US_160     160000
`define FFMD_TMR_W           32

`endif

// *** inc/ffmd_pkg.sv ***
// Types shared by the freefall/motion detector.
// Assumes the register header is on the include path.
`include "ffmd_regs.svh"

package ffmd_pkg;

  typedef enum logic [1:0] {OSM_NORMAL, OSM_LOWNOISE, OSM_HIGHRES, OSM_LOWPOWER} ffmd_osm_t;

  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
    logic signed [13:0] z;
  } ffmd_accel_t;

  typedef struct packed {
    logic [7:0]              cfg;
    logic [7:0]              ths;
    logic [7:0]              cnt_lim;
    logic [7:0]              sysctl;
    logic [7:0]              irqctl;
    logic                    ea;
    logic [5:0]              flags;
    logic [7:0]              dbc;
    logic [`FFMD_TMR_W-1:0]  tmr;
    logic                    ack;
    logic [31:0]             rdata;
  } ffmd_state_t;

endpackage : ffmd_pkg

// *** verif/ffmd_detector_asserts.sv ***
// Port-level checker for the freefall/motion detector.
// Assumes it is bound to the detector and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "ffmd_regs.svh"

module ffmd_detector_asserts #(
  parameter int unsigned CYCLES_PER_US = 100
) (
  input wire logic                  clk_sys_i,
  input wire logic                  reset_i,
  input wire logic [7:0]            avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [31:0]           avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic [31:0]           avs_readdata_o,
  input wire logic                  avs_waitrequest_o,
  input wire ffmd_pkg::ffmd_accel_t accel_i,
  input wire logic                  sample_tick_o,
  input wire logic                  event_active_o,
  input wire logic                  irq_int1_o,
  input wire logic                  irq_int2_o
);
  import ffmd_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  logic [5:0] idx;
  logic       src_take;
  assign idx = avs_address_i[7:2];
  assign src_take = avs_read_i && !avs_waitrequest_o && idx == `FFMD_IDX_SOURCE;
  sequence s_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_rd_taken; avs_read_i && !avs_waitrequest_o; endsequence
  sequence s_unmapped; s_rd_taken ##0 !(idx inside {6'h15, 6'h16, 6'h17, 6'h18, 6'h2A, 6'h2D}); endsequence
  a_wait_answer: assert property (s_wait |=> !avs_waitrequest_o) else $error("waitrequest not low on second cycle");
  a_upper_zero: assert property (s_rd_taken |-> avs_readdata_o[31:8] == 24'h0) else $error("read upper bits set");
  a_src_layout: assert property (s_rd_taken ##0 idx == `FFMD_IDX_SOURCE |-> avs_readdata_o[6] == 1'b0
    && avs_readdata_o[7] == $past(event_active_o)) else $error("source layout wrong");
  a_cfg_spare: assert property (s_rd_taken ##0 idx == `FFMD_IDX_CONFIG |-> avs_readdata_o[2:0] == 3'h0)
    else $error("config spare bits set");
  a_unmapped_zero: assert property (s_unmapped |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_tick_gap: assert property (sample_tick_o |=> !sample_tick_o [*8]) else $error("sample ticks too close");
  a_event_cause: assert property ($changed(event_active_o) |-> $past(sample_tick_o) || $past(src_take))
    else $error("event flag changed without cause");
  a_rise_tick: assert property ($rose(event_active_o) |-> $past(sample_tick_o)) else $error("event off tick");
  a_irq_event: assert property (irq_int1_o || irq_int2_o |-> event_active_o) else $error("irq without event");
  a_irq_one_pin: assert property (!(irq_int1_o && irq_int2_o)) else $error("both irq pins high");
endmodule : ffmd_detector_asserts

bind ffmd_detector ffmd_detector_asserts #(.CYCLES_PER_US(CYCLES_PER_US)) ffmd_detector_asserts_i (.clk_sys_i,
  .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .accel_i, .sample_tick_o, .event_active_o, .irq_int1_o, .irq_int2_o);
`default_nettype wire

// *** verif/ffmd_sensor_model.sv ***
// Sensing front end that feeds acceleration words to the detector.
// Assumes the bench sets the wanted word just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module ffmd_sensor_model (
  input  wire logic                  clk_sys_i,
  input  wire ffmd_pkg::ffmd_accel_t want_i,
  output ffmd_pkg::ffmd_accel_t      accel_o
);
  import ffmd_pkg::*;
  // One register stage, as a real conversion pipeline would show.
  always_ff @(posedge clk_sys_i) accel_o <= want_i;
endmodule : ffmd_sensor_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the freefall/motion detector.
// Assumes the detector, its package and the sensor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ffmd_pkg::*;
  logic             clk_sys_i = 1'b0;
  logic             reset_i   = 1'b1;
  logic [7:0]       addr      = 8'h00;
  logic             rd        = 1'b0;
  logic             wr        = 1'b0;
  logic [31:0]      wdata     = 32'h0;
  logic [3:0]       be        = 4'hF;
  wire logic [31:0] rdata;
  wire logic        wait_w, tick, ea, irq1, irq2;
  ffmd_accel_t      want      = '0;
  ffmd_accel_t      accel;
  int               num_errors = 0;
  int               compares   = 0;
  int               seed       = 32'h0B56;
  logic [7:0]       expq[$];
  logic [7:0]       regs[5]    = '{8'h54, 8'h58, 8'h5C, 8'h60, 8'hFC};
  logic             neg;
  logic [13:0]      mag;

  ffmd_detector #(.CYCLES_PER_US(1)) ffmd_detector_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_w), .accel_i(accel), .sample_tick_o(tick),
    .event_active_o(ea), .irq_int1_o(irq1), .irq_int2_o(irq2));
  ffmd_sensor_model ffmd_sensor_model_i (.clk_sys_i(clk_sys_i), .want_i(want), .accel_o(accel));

  initial forever #5 clk_sys_i = ~clk_sys_i;

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Settled values are looked at on the falling edge, so no race with the design's update.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    rd <= !w; wr <= w; addr <= a; wdata <= {24'h0, d};
    n = 0;
    do begin @(negedge clk_sys_i); n++; end while (wait_w !== 1'b0 && n < 50);
    if (n >= 50) begin num_errors++; summarize(); end
    @(posedge clk_sys_i);
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd_exp

  task automatic ticks(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do begin @(negedge clk_sys_i); n++; end while (tick !== 1'b1 && n < 2000);
      if (n >= 2000) begin num_errors++; summarize(); end
    end
    // The second edge lets the flag launched at the tick edge settle before anyone looks at it.
    repeat (2) @(posedge clk_sys_i);
  endtask : ticks

  always @(negedge clk_sys_i)
    if (rd === 1'b1 && wait_w === 1'b0) check(rdata, {24'h0, expq.pop_front()});

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    foreach (regs[i]) rd_exp(regs[i], 8'h00);
    be <= 4'h0;
    bus(1'b1, 8'h54, 8'hFF);
    be <= 4'hF;
    rd_exp(8'h54, 8'h00);
    bus(1'b1, 8'h54, 8'hFF);
    rd_exp(8'h54, 8'hF8);
    // Latched motion on X only; Y and Z sit far above threshold but are disabled.
    neg = 1'($random(seed));
    mag = 14'h1100 + 14'($unsigned($random(seed)) % 32'hED8);
    want <= '{x: neg ? -mag : mag, y: 14'h1FFF, z: 14'h2001};
    bus(1'b1, 8'h5C, 8'h10);
    bus(1'b1, 8'h60, 8'h02);
    bus(1'b1, 8'h54, 8'hC8);
    ticks(3);
    check(32'(ea), 32'h1);
    want <= '0;
    ticks(1);
    rd_exp(8'h58, {7'h41, neg});
    check(32'(ea), 32'h0);
    // Unlatched freefall with every axis exactly at threshold.
    want <= '{x: 14'h1000, y: 14'h3000, z: 14'h1000};
    bus(1'b1, 8'h60, 8'h00);
    bus(1'b1, 8'h54, 8'h38);
    ticks(2);
    check(32'(ea), 32'h1);
    rd_exp(8'h58, 8'h80);
    check(32'(ea), 32'h1);
    bus(1'b1, 8'hB4, 8'h03);
    check(32'({irq1, irq2}), 32'h1);
    bus(1'b1, 8'hB4, 8'h01);
    check(32'({irq1, irq2}), 32'h2);
    // Same gap pattern in both debounce modes: only decrement mode reaches the count.
    for (int m = 0; m < 2; m++)
    begin
      want <= '0;
      bus(1'b1, 8'h5C, {m[0], 7'h10});
      bus(1'b1, 8'h60, 8'h03);
      bus(1'b1, 8'h54, 8'h48);
      ticks(4);
      check(32'(ea), 32'h0);
      want <= '{x: 14'h1F00, y: 14'h0, z: 14'h0};
      ticks(2);
      want <= '0;
      ticks(1);
      want <= '{x: 14'h1F00, y: 14'h0, z: 14'h0};
      ticks(2);
      check(32'(ea), 32'(m == 0));
    end
    // Threshold units stay fixed across full scale; low noise clamps the reachable threshold.
    bus(1'b1, 8'h60, 8'h00);
    bus(1'b1, 8'h5C, 8'h3F);
    want <= '{x: 14'h1000, y: 14'h0, z: 14'h0};
    ticks(1);
    check(32'(ea), 32'h0);
    bus(1'b1, 8'hA8, 8'h80);
    ticks(1);
    check(32'(ea), 32'h1);
    bus(1'b1, 8'h5C, 8'h7F);
    ticks(1);
    check(32'(ea), 32'h0);
    bus(1'b1, 8'hA8, 8'h81);
    ticks(1);
    check(32'(ea), 32'h1);
    summarize();
  end
endmodule : testbench
`default_nettype wire
